// *** shared/hss_diag_pkg.sv ***
package hss_diag_pkg;
    localparam int CLK_PERIOD_NS = 5;
    // standby delay and retry times in ns
    localparam int STANDBY_DELAY_NS = 20000;
    localparam int RETRY_TIME_NS = 10000;
    // longest-time counts round down, never below one cycle
    localparam int STANDBY_DELAY_CYCLES =
        (STANDBY_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (STANDBY_DELAY_NS / CLK_PERIOD_NS);
    localparam int RETRY_CYCLES =
        (RETRY_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (RETRY_TIME_NS / CLK_PERIOD_NS);

    // register map, byte addresses
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int CTRL_VARIANT_F_BIT = 0;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_SHUT_LSB = 4;
    localparam int STAT_OPEN_LSB = 6;
    localparam int STAT_SWITCH_LSB = 8;
    localparam int STAT_SOURCE_LSB = 12;

    localparam logic [1:0] SEL_CH1 = 2'h0;
    localparam logic [1:0] SEL_CH2 = 2'h1;
    localparam logic [1:0] SEL_TEMP = 2'h2;
    localparam logic [1:0] SEL_NONE = 2'h3;

    typedef enum logic [2:0] {
        ST_STBY_DELAY = 3'b000,
        ST_STANDBY = 3'b001,
        ST_DIAGNOSTIC = 3'b010,
        ST_ACTIVE = 3'b011,
        ST_FAULT = 3'b100
    } op_state_t;

    typedef enum logic [2:0] {
        SRC_OFF = 3'b000,
        SRC_CUR1 = 3'b001,
        SRC_CUR2 = 3'b010,
        SRC_TEMP1 = 3'b011,
        SRC_TEMP2 = 3'b100,
        SRC_FAULT = 3'b101
    } sense_src_t;
endpackage : hss_diag_pkg

// *** rtl/hss_diag_ctrl.sv ***
`timescale 1ns/1ps
module hss_diag_ctrl
    import hss_diag_pkg::*;
#(
    parameter int STBY_CYCLES = STANDBY_DELAY_CYCLES,
    parameter int RETRY_LEN = RETRY_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic channel_one_enable,
    input wire logic channel_two_enable,
    input wire logic diag_enable,
    input wire logic sense_select_upper,
    input wire logic sense_select_lower,
    input wire logic latch_hold,
    input wire logic [1:0] thermal_trip,
    input wire logic [1:0] current_trip,
    input wire logic [1:0] vout_above_open,
    input wire logic ch2_hotter,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata_ff,
    output sense_src_t sense_source_ff,
    output logic sense_oe_ff,
    output logic fault_pin_one_out_ff,
    output logic fault_pin_one_oe_ff,
    output logic fault_pin_two_out_ff,
    output logic fault_pin_two_oe_ff,
    output logic [1:0] switch_on_ff,
    output logic [1:0] open_detect_en_ff,
    output logic low_power_ff,
    output op_state_t op_state_ff
);
    localparam int SCW = $clog2(STBY_CYCLES + 1);
    localparam int RCW = $clog2(RETRY_LEN + 1);
    localparam logic [SCW-1:0] STBY_LAST = SCW'(STBY_CYCLES - 1);
    localparam logic [RCW-1:0] RETRY_LOAD = RCW'(RETRY_LEN);

    logic [31:0] ctrl_ff;
    logic variant_f;
    logic [1:0] en_vec;
    logic [1:0] trip;
    logic [1:0] shut_vec;
    logic [1:0] open_vec;
    logic [1:0] fault_detect;
    logic [1:0] sel_code;
    logic any_high;
    logic [SCW-1:0] stby_cnt_ff;
    logic stby_done;
    op_state_t nxt_op_state;
    sense_src_t nxt_sense_source;
    logic nxt_sense_oe;
    logic [1:0] nxt_fault_oe;

    assign variant_f = ctrl_ff[CTRL_VARIANT_F_BIT];
    assign en_vec = {channel_two_enable, channel_one_enable};
    assign trip = thermal_trip | current_trip;
    assign any_high = |en_vec | diag_enable;
    assign sel_code = {sense_select_upper, sense_select_lower};
    assign stby_done = (stby_cnt_ff == STBY_LAST);
    assign fault_detect = shut_vec | open_vec;

    // per-channel shutdown, retry timer and open-load flag
    for (genvar i = 0; i < 2; i++) begin : g_ch
        logic shut_ff;
        logic open_ff;
        logic [RCW-1:0] retry_cnt_ff;

        always_ff @(posedge clk_sys) begin
            if (rst) begin
                shut_ff <= 1'b0;
                retry_cnt_ff <= '0;
            end else if (!shut_ff) begin
                if (trip[i]) begin
                    shut_ff <= 1'b1;
                    retry_cnt_ff <= RETRY_LOAD;
                end
            end else begin
                if (retry_cnt_ff != '0) begin
                    retry_cnt_ff <= retry_cnt_ff - 1'b1;
                end else if (!trip[i] && !latch_hold) begin
                    shut_ff <= 1'b0;
                end
            end
        end

        // follows the comparator while detection is on, so the
        // diag fall and enable rise both clear it at once
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                open_ff <= 1'b0;
            end else begin
                open_ff <= diag_enable && !en_vec[i]
                    && vout_above_open[i];
            end
        end

        always_ff @(posedge clk_sys) begin
            if (rst) begin
                switch_on_ff[i] <= 1'b0;
                open_detect_en_ff[i] <= 1'b0;
            end else begin
                // channel only sees its own shutdown
                switch_on_ff[i] <= en_vec[i] && !shut_ff;
                open_detect_en_ff[i] <= diag_enable
                    && !en_vec[i];
            end
        end

        assign shut_vec[i] = shut_ff;
        assign open_vec[i] = open_ff;
    end

    // standby delay counter
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stby_cnt_ff <= '0;
        end else if (any_high) begin
            stby_cnt_ff <= '0;
        end else if (!stby_done) begin
            stby_cnt_ff <= stby_cnt_ff + 1'b1;
        end
    end

    always_comb begin
        if (|shut_vec) begin
            nxt_op_state = ST_FAULT;
        end else if (|en_vec) begin
            nxt_op_state = ST_ACTIVE;
        end else if (diag_enable) begin
            nxt_op_state = ST_DIAGNOSTIC;
        end else if (op_state_ff == ST_STANDBY) begin
            nxt_op_state = ST_STANDBY;
        end else if (op_state_ff == ST_STBY_DELAY && stby_done) begin
            nxt_op_state = ST_STANDBY;
        end else begin
            nxt_op_state = ST_STBY_DELAY;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            op_state_ff <= ST_STBY_DELAY;
            low_power_ff <= 1'b0;
        end else begin
            op_state_ff <= nxt_op_state;
            low_power_ff <= (nxt_op_state == ST_STANDBY);
        end
    end

    // sense multiplexer and fault pins
    always_comb begin
        nxt_sense_source = SRC_OFF;
        nxt_sense_oe = 1'b0;
        nxt_fault_oe = 2'b00;
        if (!diag_enable) begin
            nxt_sense_oe = 1'b0;
        end else if (variant_f) begin
            nxt_sense_oe = 1'b1;
            // upper select ignored, no temperature here
            if (!sense_select_lower) begin
                nxt_sense_source = fault_detect[0] ? SRC_FAULT
                                                   : SRC_CUR1;
            end else begin
                nxt_sense_source = fault_detect[1] ? SRC_FAULT
                                                   : SRC_CUR2;
            end
            nxt_fault_oe = fault_detect;
        end else begin
            unique case (sel_code)
                SEL_CH1: begin
                    nxt_sense_oe = 1'b1;
                    nxt_sense_source = fault_detect[0] ? SRC_FAULT
                                                       : SRC_CUR1;
                end
                SEL_CH2: begin
                    nxt_sense_oe = 1'b1;
                    nxt_sense_source = fault_detect[1] ? SRC_FAULT
                                                       : SRC_CUR2;
                end
                SEL_TEMP: begin
                    nxt_sense_oe = 1'b1;
                    nxt_sense_source = ch2_hotter ? SRC_TEMP2
                                                  : SRC_TEMP1;
                end
                SEL_NONE: begin
                    nxt_sense_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sense_source_ff <= SRC_OFF;
            sense_oe_ff <= 1'b0;
            fault_pin_one_oe_ff <= 1'b0;
            fault_pin_two_oe_ff <= 1'b0;
            fault_pin_one_out_ff <= 1'b0;
            fault_pin_two_out_ff <= 1'b0;
        end else begin
            sense_source_ff <= nxt_sense_source;
            sense_oe_ff <= nxt_sense_oe;
            fault_pin_one_oe_ff <= nxt_fault_oe[0];
            fault_pin_two_oe_ff <= nxt_fault_oe[1];
            fault_pin_one_out_ff <= 1'b0;
            fault_pin_two_out_ff <= 1'b0;
        end
    end

    // register port
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_ff <= CTRL_RESET;
        end else if (reg_wr && reg_addr == ADDR_CTRL) begin
            ctrl_ff <= {31'h0, reg_wdata[CTRL_VARIANT_F_BIT]};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata_ff <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata_ff <= 32'h0000_0000;
            if (reg_addr == ADDR_CTRL) begin
                reg_rdata_ff <= ctrl_ff;
            end else if (reg_addr == ADDR_STATUS) begin
                reg_rdata_ff[STAT_STATE_LSB +: 3] <= op_state_ff;
                reg_rdata_ff[STAT_SHUT_LSB +: 2] <= shut_vec;
                reg_rdata_ff[STAT_OPEN_LSB +: 2] <= open_vec;
                reg_rdata_ff[STAT_SWITCH_LSB +: 2] <= switch_on_ff;
                reg_rdata_ff[STAT_SOURCE_LSB +: 3] <= sense_source_ff;
            end
        end else begin
            reg_rdata_ff <= 32'h0000_0000;
        end
    end

    // checks
    property p_diag_off_hiz;
        @(posedge clk_sys) disable iff (rst)
        !diag_enable |=> !sense_oe_ff && !fault_pin_one_oe_ff
            && !fault_pin_two_oe_ff;
    endproperty
    a_diag_off_hiz: assert property (p_diag_off_hiz)
        else $error("sense or fault pin driven with diag off");

    property p_cur_fault;
        @(posedge clk_sys) disable iff (rst)
        diag_enable && !variant_f && sel_code == SEL_CH1
            && fault_detect[0] |=> sense_source_ff == SRC_FAULT;
    endproperty
    a_cur_fault: assert property (p_cur_fault)
        else $error("channel one fault not on sense");

    property p_temp_kept;
        @(posedge clk_sys) disable iff (rst)
        diag_enable && !variant_f && sel_code == SEL_TEMP
            |=> sense_source_ff == (
                $past(ch2_hotter) ? SRC_TEMP2 : SRC_TEMP1);
    endproperty
    a_temp_kept: assert property (p_temp_kept)
        else $error("temperature select not hotter channel");

    property p_flt_own;
        @(posedge clk_sys) disable iff (rst)
        variant_f && diag_enable && !fault_detect[1]
            && fault_detect[0] |=> fault_pin_one_oe_ff
            && !fault_pin_two_oe_ff && !fault_pin_one_out_ff;
    endproperty
    a_flt_own: assert property (p_flt_own)
        else $error("fault pin shows wrong channel");

    property p_ab_no_flt;
        @(posedge clk_sys) disable iff (rst)
        !variant_f |=> !fault_pin_one_oe_ff && !fault_pin_two_oe_ff;
    endproperty
    a_ab_no_flt: assert property (p_ab_no_flt)
        else $error("fault pin driven on a/b variant");

    property p_no_open_when_on;
        @(posedge clk_sys) disable iff (rst)
        channel_one_enable |=> !open_vec[0];
    endproperty
    a_no_open_when_on: assert property (p_no_open_when_on)
        else $error("open-load shown on enabled channel");

    property p_stby_restart;
        @(posedge clk_sys) disable iff (rst)
        op_state_ff == ST_STBY_DELAY && any_high
            ##1 !any_high |=> op_state_ff != ST_STANDBY;
    endproperty
    a_stby_restart: assert property (p_stby_restart)
        else $error("standby entered without full delay");

    property p_retry_hold;
        @(posedge clk_sys) disable iff (rst)
        $rose(shut_vec[0]) |-> shut_vec[0] [*8];
    endproperty
    a_retry_hold: assert property (p_retry_hold)
        else $error("shutdown released before retry timer");

    property p_fault_state;
        @(posedge clk_sys) disable iff (rst)
        |shut_vec |=> op_state_ff == ST_FAULT;
    endproperty
    a_fault_state: assert property (p_fault_state)
        else $error("fault state missed on shutdown");

    property p_independent;
        @(posedge clk_sys) disable iff (rst)
        shut_vec[0] && !shut_vec[1] && channel_two_enable
            |=> switch_on_ff[1] && !switch_on_ff[0];
    endproperty
    a_independent: assert property (p_independent)
        else $error("channel two disturbed by channel one fault");

    property p_active;
        @(posedge clk_sys) disable iff (rst)
        |en_vec && !(|shut_vec) |=> op_state_ff == ST_ACTIVE;
    endproperty
    a_active: assert property (p_active)
        else $error("not active with switch enabled");

    property p_open_det_en;
        @(posedge clk_sys) disable iff (rst)
        !diag_enable || channel_two_enable |=> !open_detect_en_ff[1];
    endproperty
    a_open_det_en: assert property (p_open_det_en)
        else $error("open-load detection on outside off-state diag");

    property p_latch_keeps;
        @(posedge clk_sys) disable iff (rst)
        shut_vec[0] && latch_hold |=> shut_vec[0];
    endproperty
    a_latch_keeps: assert property (p_latch_keeps)
        else $error("shutdown released while latch held");

    property p_no_early_standby;
        @(posedge clk_sys) disable iff (rst)
        any_high |=> op_state_ff != ST_STANDBY;
    endproperty
    a_no_early_standby: assert property (p_no_early_standby)
        else $error("standby entered with an enable high");

    c_standby: cover property (@(posedge clk_sys) disable iff (rst)
        op_state_ff == ST_STANDBY);
    c_fault_exit: cover property (@(posedge clk_sys) disable iff (rst)
        op_state_ff == ST_FAULT ##1 op_state_ff == ST_ACTIVE);
    c_temp: cover property (@(posedge clk_sys) disable iff (rst)
        sense_source_ff == SRC_TEMP2);
    c_flt_pin: cover property (@(posedge clk_sys) disable iff (rst)
        fault_pin_two_oe_ff);
endmodule : hss_diag_ctrl

// *** test/host_mcu_model.sv ***
`timescale 1ns/1ps
module host_mcu_model
    import hss_diag_pkg::*;
#(
    parameter int SETTLE = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic restart,
    input wire logic [1:0] cmd_en,
    input wire logic cmd_diag,
    input wire logic [1:0] cmd_sel,
    input wire logic cmd_latch,
    input wire logic variant_f,
    input wire sense_src_t sense_source_ff,
    output logic channel_one_enable,
    output logic channel_two_enable,
    output logic diag_enable,
    output logic sense_select_upper,
    output logic sense_select_lower,
    output logic latch_hold,
    output sense_src_t med_src,
    output logic med_valid
);
    logic [7:0] age_ff;
    sense_src_t smp_ff [3];

    function automatic sense_src_t mid3(sense_src_t a, sense_src_t b,
        sense_src_t c);
        if ((a <= b && b <= c) || (c <= b && b <= a)) return b;
        if ((b <= a && a <= c) || (c <= a && a <= b)) return a;
        return c;
    endfunction : mid3

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            {channel_one_enable, channel_two_enable, diag_enable,
                sense_select_upper, sense_select_lower, latch_hold} <= 6'h00;
        end else begin
            channel_one_enable <= cmd_en[0];
            channel_two_enable <= cmd_en[1];
            diag_enable <= cmd_diag;
            sense_select_upper <= cmd_sel[1] & ~variant_f;
            sense_select_lower <= cmd_sel[0];
            latch_hold <= cmd_latch;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || restart) begin
            age_ff <= 8'h00;
        end else if (age_ff != 8'hFF) begin
            age_ff <= age_ff + 8'h01;
        end
    end

    // three samples, only once the sense output has settled
    always_ff @(posedge clk_sys) begin
        for (int k = 0; k < 3; k++) begin
            if (int'(age_ff) == SETTLE + k) begin
                smp_ff[k] <= sense_source_ff;
            end
        end
    end

    assign med_src = mid3(smp_ff[0], smp_ff[1], smp_ff[2]);
    assign med_valid = int'(age_ff) > SETTLE + 2;
endmodule : host_mcu_model

// *** test/dual_switch_diag_mux_modes_test.sv ***
`timescale 1ns/1ps
module dual_switch_diag_mux_modes_test;
    import hss_diag_pkg::*;
    localparam int STBY = 16;
    localparam int RETRY = 12;
    logic clk_sys, rst, ch2_hotter, reg_wr, reg_rd, restart, med_valid;
    logic channel_one_enable, channel_two_enable, diag_enable, latch_hold;
    logic sense_select_upper, sense_select_lower, sense_oe_ff, low_power_ff;
    logic f1_out, f1_oe, f2_out, f2_oe, cmd_diag, cmd_latch, variant_f;
    logic [1:0] thermal_trip, current_trip, vout_above_open, switch_on_ff;
    logic [1:0] open_detect_en_ff, cmd_en, cmd_sel, en, s, v, flt;
    logic d, hot;
    logic [3:0] reg_addr, e;
    logic [31:0] reg_wdata, reg_rdata_ff, rdat;
    sense_src_t sense_source_ff, med_src;
    op_state_t op_state_ff;
    int errors, num_checks;

    hss_diag_ctrl #(.STBY_CYCLES(STBY), .RETRY_LEN(RETRY))
    hss_diag_ctrl_i (
        .clk_sys(clk_sys), .rst(rst),
        .channel_one_enable(channel_one_enable),
        .channel_two_enable(channel_two_enable), .diag_enable(diag_enable),
        .sense_select_upper(sense_select_upper),
        .sense_select_lower(sense_select_lower), .latch_hold(latch_hold),
        .thermal_trip(thermal_trip), .current_trip(current_trip),
        .vout_above_open(vout_above_open), .ch2_hotter(ch2_hotter),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
        .sense_source_ff(sense_source_ff), .sense_oe_ff(sense_oe_ff),
        .fault_pin_one_out_ff(f1_out), .fault_pin_one_oe_ff(f1_oe),
        .fault_pin_two_out_ff(f2_out), .fault_pin_two_oe_ff(f2_oe),
        .switch_on_ff(switch_on_ff), .open_detect_en_ff(open_detect_en_ff),
        .low_power_ff(low_power_ff), .op_state_ff(op_state_ff)
    );

    host_mcu_model host_mcu_model_i (
        .clk_sys(clk_sys), .rst(rst), .restart(restart), .cmd_en(cmd_en),
        .cmd_diag(cmd_diag), .cmd_sel(cmd_sel), .cmd_latch(cmd_latch),
        .variant_f(variant_f), .sense_source_ff(sense_source_ff),
        .channel_one_enable(channel_one_enable),
        .channel_two_enable(channel_two_enable), .diag_enable(diag_enable),
        .sense_select_upper(sense_select_upper),
        .sense_select_lower(sense_select_lower), .latch_hold(latch_hold),
        .med_src(med_src), .med_valid(med_valid)
    );

    function automatic logic [3:0] exp_sns(logic a_d, logic [1:0] a_s,
        logic a_f, logic [1:0] a_flt, logic a_h);
        logic [1:0] c;
        c = a_f ? {1'b0, a_s[0]} : a_s;
        if (!a_d || c == SEL_NONE) return 4'h0;
        if (c == SEL_TEMP) return {1'b1, a_h ? SRC_TEMP2 : SRC_TEMP1};
        if (a_flt[c[0]]) return {1'b1, SRC_FAULT};
        return {1'b1, c[0] ? SRC_CUR2 : SRC_CUR1};
    endfunction : exp_sns

    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] w);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= w;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        rdat = reg_rdata_ff;
    endtask : rd_reg

    task automatic set_var(input logic a_f);
        wr_reg(ADDR_CTRL, {31'h0, a_f});
        variant_f <= a_f;
    endtask : set_var

    task automatic apply(input logic [1:0] a_en, input logic a_d,
        input logic [1:0] a_s, input logic [1:0] a_v, input logic a_h);
        int n;
        @(posedge clk_sys);
        cmd_en <= a_en;
        cmd_diag <= a_d;
        cmd_sel <= a_s;
        vout_above_open <= a_v;
        ch2_hotter <= a_h;
        restart <= 1'b1;
        @(posedge clk_sys);
        restart <= 1'b0;
        #1;
        for (n = 0; n < 40 && med_valid !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
        end
        if (med_valid !== 1'b1) begin
            errors++;
            $display("[ERR] %0t sample timeout", $time);
            final_report();
        end
    endtask : apply

    task automatic trip_case(input logic [1:0] a_s, input logic ch,
        input logic lat, input logic [1:0] en_x, input logic a_f);
        set_var(a_f);
        @(posedge clk_sys);
        cmd_latch <= lat;
        apply(2'b11, 1'b1, a_s, 2'b00, 1'b0);
        @(posedge clk_sys);
        if (ch) thermal_trip <= 2'b10;
        else current_trip <= 2'b01;
        repeat (3) @(posedge clk_sys);
        #1;
        e = exp_sns(1'b1, a_s, a_f, ch ? 2'b10 : 2'b01, 1'b0);
        chk({sense_oe_ff, sense_source_ff}, e);
        chk(switch_on_ff, ch ? 2'b01 : 2'b10);
        chk(op_state_ff, ST_FAULT);
        if (a_f) chk({f2_oe, f1_oe}, ch ? 2'b10 : 2'b01);
        @(posedge clk_sys);
        thermal_trip <= 2'b00;
        current_trip <= 2'b00;
        cmd_en <= en_x;
        repeat (RETRY + 10) @(posedge clk_sys);
        #1;
        if (lat) begin
            chk(op_state_ff, ST_FAULT);
            @(posedge clk_sys);
            cmd_latch <= 1'b0;
            repeat (6) @(posedge clk_sys);
            #1;
        end
        chk({op_state_ff, switch_on_ff}, {ST_ACTIVE, en_x});
    endtask : trip_case

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    initial begin
        rst = 1'b1;
        {reg_wr, reg_rd, restart, cmd_diag, cmd_latch, variant_f} = 6'h00;
        {thermal_trip, current_trip, vout_above_open, cmd_en} = 8'h00;
        {cmd_sel, ch2_hotter, reg_addr, reg_wdata} = 39'h0;
        errors = 0;
        num_checks = 0;
        void'($urandom(32'h45CC30F4));
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        rd_reg(ADDR_CTRL);
        chk(rdat, CTRL_RESET);
        chk(op_state_ff, ST_STBY_DELAY);
        wr_reg(ADDR_CTRL, 32'hFFFF_FFFF);
        wr_reg(4'h8, 32'hFFFF_FFFF);
        rd_reg(ADDR_CTRL);
        chk(rdat, 32'h0000_0001);
        rd_reg(4'h8);
        chk(rdat, 32'h0000_0000);
        for (int i = 0; i < 40; i++) begin
            set_var(1'($urandom));
            {en, d, s, v, hot} = 8'($urandom);
            apply(en, d, s, v, hot);
            flt = {2{d}} & ~en & v;
            e = exp_sns(d, s, variant_f, flt, hot);
            chk(sense_oe_ff, e[3]);
            if (e[3]) chk(med_src, e[2:0]);
            if (variant_f) chk({f2_out, f1_out, f2_oe, f1_oe}, flt);
            chk(switch_on_ff, en);
            chk(open_detect_en_ff, {2{d}} & ~en);
            if (en != 2'b00) chk(op_state_ff, ST_ACTIVE);
            else if (d) chk(op_state_ff, ST_DIAGNOSTIC);
            rd_reg(ADDR_STATUS);
            chk(rdat[9:8], en);
        end
        apply(2'b00, 1'b1, 2'b00, 2'b00, 1'b0);
        apply(2'b00, 1'b0, 2'b00, 2'b00, 1'b0);
        chk(op_state_ff, ST_STBY_DELAY);
        apply(2'b00, 1'b1, 2'b00, 2'b00, 1'b0);
        apply(2'b00, 1'b0, 2'b00, 2'b00, 1'b0);
        repeat (STBY - 10) @(posedge clk_sys);
        #1;
        chk(op_state_ff, ST_STBY_DELAY);
        repeat (12) @(posedge clk_sys);
        #1;
        chk({low_power_ff, op_state_ff}, {1'b1, ST_STANDBY});
        trip_case(SEL_CH1, 1'b0, 1'b0, 2'b11, 1'b0);
        trip_case(SEL_CH2, 1'b0, 1'b0, 2'b10, 1'b1);
        trip_case(SEL_TEMP, 1'b0, 1'b0, 2'b11, 1'b0);
        trip_case(SEL_CH2, 1'b1, 1'b1, 2'b11, 1'b1);
        final_report();
    end
endmodule : dual_switch_diag_mux_modes_test
